// *** src/adc_cal_pkg.sv ***
// Package with register map, timing constants and types of the calibration sequencer.
package adc_cal_pkg;

    // ****************************************************************
    // Register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [7:0] SETUP_OFFSET  = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] ZS_OFFSET     = 8'h08;
    localparam logic [7:0] FS_OFFSET     = 8'h0c;
    localparam logic [7:0] DATA_OFFSET   = 8'h10;

    // Setup field positions.
    localparam int MODE_LOW_POS  = 0;
    localparam int MODE_HIGH_POS = 1;
    localparam int GAIN_LSB_POS  = 2;
    localparam int BIPOLAR_POS   = 5;
    localparam int CHANNEL_POS   = 6;

    // Status field positions.
    localparam int READY_N_POS = 0;
    localparam int BUSY_POS    = 1;

    // Calibration mode codes {high bit, low bit}.
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_SELF    = 2'h1;
    localparam logic [1:0] MODE_SYS_ZS  = 2'h2;
    localparam logic [1:0] MODE_SYS_FS  = 2'h3;

    // Reset values.
    localparam logic [15:0] ZS_DEFAULT    = 16'h0000;
    localparam logic [15:0] FS_DEFAULT    = 16'hffff;
    localparam logic [15:0] DATA_DEFAULT  = 16'h0000;
    localparam logic [2:0]  GAIN_DEFAULT  = 3'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS    = 4;
    localparam int MOD_CYCLE_CLKS   = 128;
    localparam int MOD_PER_WORD     = 16;
    localparam int WORD_CLKS        = MOD_CYCLE_CLKS * MOD_PER_WORD;
    localparam logic [3:0] STEP_WORDS      = 4'h3;
    localparam logic [3:0] SELF_CONV_WORDS = 4'h3;
    localparam logic [3:0] SYS_CONV_WORDS  = 4'h1;

    // Correction scale for the two ranges.
    localparam logic signed [17:0] UNI_SPAN_CODE = 18'sh0ffff;
    localparam logic signed [17:0] BI_SPAN_CODE  = 18'sh08000;
    localparam logic signed [17:0] BI_MID_CODE   = 18'sh08000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ZERO   = 4'h2,
        ST_FULL   = 4'h4,
        ST_SETTLE = 4'h8
    } cal_state_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    typedef struct packed {
        logic       short_inputs;
        logic       internal_ref;
        logic [2:0] pga_gain;
        logic       bipolar;
        logic       channel;
    } front_ctrl_type;

endpackage : adc_cal_pkg

// *** src/word_timer.sv ***
// Output-word period divider producing a one-cycle tick each word.
`timescale 1ns/1ps
module word_timer
    import adc_cal_pkg::*;
(
    input  wire logic clk,       // System clock
    input  wire logic arst_n,    // Asynchronous reset, active low
    input  wire logic restart,   // Realigns the period to this cycle
    output logic      word_tick  // One-cycle pulse at each word end
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } timer_state_type;

    localparam logic [15:0] LAST_CNT = 16'(WORD_CLKS - 1);

    timer_state_type cur_ff;
    timer_state_type nxt_state;

    always_comb begin
        nxt_state      = cur_ff;
        nxt_state.tick = 1'b0;
        if (restart) begin
            nxt_state.cnt = 16'h0000;
        end else if (cur_ff.cnt == LAST_CNT) begin
            nxt_state.cnt  = 16'h0000;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.cnt = cur_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign word_tick = cur_ff.tick;

endmodule : word_timer

// *** src/adc_calibration_sequencer.sv ***
// Calibration sequencer of a sigma-delta converter with its register slave.
//
// Behaviour
// - Mode write accepted anytime, starts calibration immediately.
// - Mode code 0,1 starts self-calibration.
// - Self zero step: inputs shorted, selected gain.
// - Self full step: internal reference over gain.
// - Self-calibration six words, then mode reads zero.
// - Ready high at start until new word.
// - Self-calibration: ready low after nine words.
// - Ready may take one modulator cycle rising.
// - Bipolar self zero point means midscale.
// - Code 1,0: system zero step, three words.
// - Code 1,1: system full step, three words.
// - System step: ready low after four words.
// - System span: endpoints unipolar, midscale-to-full bipolar.
// - Lone system step updates only its coefficient.
// - Measurements stored in zero and full registers.
// - Offset and slope correction from coefficients.
// - Self-calibration leaves attenuator mismatch uncorrected.
// - Reset loads nominal coefficient defaults.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module adc_calibration_sequencer
    import adc_cal_pkg::*;
(
    input  wire logic     clk,            // System clock, 250 MHz
    input  wire logic     arst_n,         // Asynchronous reset, active low
    input  bus_req_type   bus_req,        // Register request: addr, wdata, wr, rd
    output logic [31:0]   rdata,          // Read data, valid the cycle after rd
    input  wire logic [15:0] meas_word,   // Raw filter word, valid at each word end
    output front_ctrl_type front_ctrl,    // Input mux, reference and gain control
    output logic          result_ready_n  // Low while a fresh data word waits
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        cal_state_type  st;
        logic [1:0]     mode;
        logic           self_seq;
        logic [3:0]     words;
        logic [2:0]     gain;
        logic           bipolar;
        logic           channel;
        logic [15:0]    zs;
        logic [15:0]    fs;
        logic [15:0]    data;
        logic           ready_n;
        logic [31:0]    rdata;
        front_ctrl_type fc;
    } seq_state_type;

    seq_state_type cur_ff;
    seq_state_type nxt_state;

    logic word_tick;
    logic setup_wr;
    logic cmd_start;

    // ****************************************************************
    // Correction of a raw word by the stored points
    // ****************************************************************
    // The divide is combinational; it is used once per word, so the long
    // path is accepted instead of a multi-cycle divider.
    function automatic logic [15:0] correct_word(
        input logic [15:0] raw,
        input logic [15:0] zpt,
        input logic [15:0] fpt,
        input logic        bip
    );
        logic signed [17:0] span;
        logic signed [17:0] diff;
        logic signed [35:0] prod;
        logic signed [35:0] quot;
        logic signed [35:0] res;
        span = $signed({2'b00, fpt}) - $signed({2'b00, zpt});
        diff = $signed({2'b00, raw}) - $signed({2'b00, zpt});
        prod = 36'(diff * (bip ? BI_SPAN_CODE : UNI_SPAN_CODE));
        quot = 36'sh0;
        res  = 36'sh0;
        if (span <= 18'sh0) begin
            correct_word = raw;
        end else begin
            quot = prod / 36'(span);
            res  = bip ? quot + 36'(BI_MID_CODE) : quot;
            if (res < 36'sh0) begin
                correct_word = 16'h0000;
            end else if (res > 36'sh0ffff) begin
                correct_word = 16'hffff;
            end else begin
                correct_word = res[15:0];
            end
        end
    endfunction : correct_word

    // Mode field {high bit, low bit} of a setup word.
    function automatic logic [1:0] mode_field(input logic [31:0] word);
        mode_field = {word[MODE_HIGH_POS], word[MODE_LOW_POS]};
    endfunction : mode_field

    // ****************************************************************
    // Command decode
    // ****************************************************************
    assign setup_wr  = bus_req.wr && (bus_req.addr == SETUP_OFFSET);
    assign cmd_start = setup_wr && (mode_field(bus_req.wdata) != MODE_NORMAL);

    // Realigning the word timer makes every step a whole number of words
    // counted from the command write.
    word_timer u_word_timer (
        .clk       (clk),
        .arst_n    (arst_n),
        .restart   (cmd_start),
        .word_tick (word_tick)
    );

    // ****************************************************************
    // Sequencer and register file
    // ****************************************************************
    always_comb begin
        nxt_state       = cur_ff;
        nxt_state.rdata = 32'h0000_0000;

        // Register writes.
        if (bus_req.wr) begin
            case (bus_req.addr)
                SETUP_OFFSET: begin
                    nxt_state.gain    = bus_req.wdata[GAIN_LSB_POS +: 3];
                    nxt_state.bipolar = bus_req.wdata[BIPOLAR_POS];
                    nxt_state.channel = bus_req.wdata[CHANNEL_POS];
                end
                ZS_OFFSET: begin
                    nxt_state.zs = bus_req.wdata[15:0];
                end
                FS_OFFSET: begin
                    nxt_state.fs = bus_req.wdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // Reading the data word hands it over; the next word lowers ready again.
        if (bus_req.rd && (bus_req.addr == DATA_OFFSET)) begin
            nxt_state.ready_n = 1'b1;
        end

        case (cur_ff.st)
            ST_IDLE: begin
                if (word_tick) begin
                    nxt_state.data    = correct_word(meas_word, cur_ff.zs, cur_ff.fs,
                                                     cur_ff.bipolar);
                    nxt_state.ready_n = 1'b0;
                end
            end
            ST_ZERO: begin
                if (word_tick) begin
                    nxt_state.words = cur_ff.words - 4'h1;
                    if (cur_ff.words == 4'h1) begin
                        nxt_state.zs = meas_word;
                        if (cur_ff.self_seq) begin
                            nxt_state.st              = ST_FULL;
                            nxt_state.words           = STEP_WORDS;
                            nxt_state.fc.short_inputs = 1'b0;
                            nxt_state.fc.internal_ref = 1'b1;
                        end else begin
                            nxt_state.st              = ST_SETTLE;
                            nxt_state.words           = SYS_CONV_WORDS;
                            nxt_state.mode            = MODE_NORMAL;
                        end
                    end
                end
            end
            ST_FULL: begin
                if (word_tick) begin
                    nxt_state.words = cur_ff.words - 4'h1;
                    if (cur_ff.words == 4'h1) begin
                        nxt_state.fs              = meas_word;
                        nxt_state.st              = ST_SETTLE;
                        nxt_state.mode            = MODE_NORMAL;
                        nxt_state.fc.internal_ref = 1'b0;
                        nxt_state.words = cur_ff.self_seq ? SELF_CONV_WORDS : SYS_CONV_WORDS;
                    end
                end
            end
            ST_SETTLE: begin
                nxt_state.ready_n = 1'b1;
                if (word_tick) begin
                    nxt_state.words = cur_ff.words - 4'h1;
                    if (cur_ff.words == 4'h1) begin
                        nxt_state.st      = ST_IDLE;
                        nxt_state.data    = correct_word(meas_word, cur_ff.zs, cur_ff.fs,
                                                         cur_ff.bipolar);
                        nxt_state.ready_n = 1'b0;
                    end
                end
            end
            default: begin
                nxt_state.st = ST_IDLE;
            end
        endcase

        // A new command overrides any step in progress; mode zero aborts.
        if (setup_wr) begin
            nxt_state.mode = mode_field(bus_req.wdata);
            nxt_state.fc.short_inputs = 1'b0;
            nxt_state.fc.internal_ref = 1'b0;
            nxt_state.self_seq        = 1'b0;
            nxt_state.words           = STEP_WORDS;
            case (nxt_state.mode)
                MODE_SELF: begin
                    // The internal nodes sit behind the attenuator, so its
                    // resistor mismatch stays in the result.
                    nxt_state.st              = ST_ZERO;
                    nxt_state.self_seq        = 1'b1;
                    nxt_state.fc.short_inputs = 1'b1;
                end
                MODE_SYS_ZS: begin
                    nxt_state.st = ST_ZERO;
                end
                MODE_SYS_FS: begin
                    nxt_state.st = ST_FULL;
                end
                default: begin
                    nxt_state.st = ST_IDLE;
                end
            endcase
            if (cmd_start) begin
                nxt_state.ready_n = 1'b1;
            end
        end

        nxt_state.fc.pga_gain = nxt_state.gain;
        nxt_state.fc.bipolar  = nxt_state.bipolar;
        nxt_state.fc.channel  = nxt_state.channel;

        // Register reads, answered in the next cycle only.
        if (bus_req.rd) begin
            case (bus_req.addr)
                SETUP_OFFSET: begin
                    nxt_state.rdata[MODE_LOW_POS]       = cur_ff.mode[0];
                    nxt_state.rdata[MODE_HIGH_POS]      = cur_ff.mode[1];
                    nxt_state.rdata[GAIN_LSB_POS +: 3]  = cur_ff.gain;
                    nxt_state.rdata[BIPOLAR_POS]        = cur_ff.bipolar;
                    nxt_state.rdata[CHANNEL_POS]        = cur_ff.channel;
                end
                STATUS_OFFSET: begin
                    nxt_state.rdata[READY_N_POS] = cur_ff.ready_n;
                    nxt_state.rdata[BUSY_POS]    = (cur_ff.st != ST_IDLE);
                end
                ZS_OFFSET: begin
                    nxt_state.rdata[15:0] = cur_ff.zs;
                end
                FS_OFFSET: begin
                    nxt_state.rdata[15:0] = cur_ff.fs;
                end
                DATA_OFFSET: begin
                    nxt_state.rdata[15:0] = cur_ff.data;
                end
                default: begin
                    nxt_state.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff          <= '0;
            cur_ff.st       <= ST_IDLE;
            cur_ff.mode     <= MODE_NORMAL;
            cur_ff.gain     <= GAIN_DEFAULT;
            cur_ff.fc.pga_gain <= GAIN_DEFAULT;
            cur_ff.zs       <= ZS_DEFAULT;
            cur_ff.fs       <= FS_DEFAULT;
            cur_ff.data     <= DATA_DEFAULT;
            cur_ff.ready_n  <= 1'b1;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign rdata          = cur_ff.rdata;
    assign front_ctrl     = cur_ff.fc;
    assign result_ready_n = cur_ff.ready_n;

endmodule : adc_calibration_sequencer

// *** sim/adc_cal_checker_sva.sv ***
// Checker of calibration sequencing at the sequencer ports.
`timescale 1ns/1ps
module adc_cal_checker
    import adc_cal_pkg::*;
(
    input wire logic        clk,            // System clock
    input wire logic        arst_n,         // Reset, active low
    input bus_req_type      bus_req,        // Register request
    input wire logic [31:0] rdata,          // Read data
    input wire logic [15:0] meas_word,      // Raw filter word
    input front_ctrl_type   front_ctrl,     // Front-end control
    input wire logic        result_ready_n  // Fresh word flag, active low
);
    localparam int W = WORD_CLKS;
    logic        act_ff;
    logic        self_ff;
    logic [15:0] cnt_ff;
    logic        setup_wr;
    logic        cal_wr;
    logic [15:0] lim;
    assign setup_wr = bus_req.wr && bus_req.addr == SETUP_OFFSET;
    assign cal_wr   = setup_wr && bus_req.wdata[1:0] != MODE_NORMAL;
    assign lim      = self_ff ? 16'(9 * W) : 16'(4 * W);
    // A new setup write restarts the count, since every setup write restarts the sequence or, with mode zero, aborts it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_ff  <= 1'b0;
            self_ff <= 1'b0;
            cnt_ff  <= 16'h0000;
        end else if (setup_wr) begin
            act_ff  <= cal_wr;
            self_ff <= bus_req.wdata[1:0] == MODE_SELF;
            cnt_ff  <= 16'h0000;
        end else if (act_ff) begin
            cnt_ff <= cnt_ff + 16'h0001;
            act_ff <= cnt_ff != lim + 16'h0008;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_READY_RISE: assert property (
        cal_wr |=> result_ready_n [*8]) else $error("ready flag not raised at start");
    AST_SELF_SHORT: assert property (
        cal_wr && bus_req.wdata[1:0] == MODE_SELF |=> front_ctrl.short_inputs
        && !front_ctrl.internal_ref) else $error("self zero step not on shorted inputs");
    AST_SYS_EXT: assert property (
        cal_wr && bus_req.wdata[1] |=> !front_ctrl.short_inputs && !front_ctrl.internal_ref)
        else $error("system step not on external input");
    AST_GAIN_COPY: assert property (
        setup_wr |=> front_ctrl.pga_gain == $past(bus_req.wdata[4:2]))
        else $error("gain not applied");
    AST_RANGE_COPY: assert property (
        setup_wr |=> front_ctrl.bipolar == $past(bus_req.wdata[5]))
        else $error("range not applied");
    AST_EXCLUSIVE: assert property (
        !(front_ctrl.short_inputs && front_ctrl.internal_ref)) else $error("short and ref both on");
    AST_READY_HELD: assert property (
        act_ff && cnt_ff < lim - 16'h0002 |-> result_ready_n) else $error("ready flag fell early");
    AST_READY_DUE: assert property (
        act_ff && cnt_ff == lim + 16'h0004 |-> !result_ready_n) else $error("ready flag late");
    AST_REF_STEP: assert property (
        act_ff && self_ff && cnt_ff == 16'(3 * W + 4) |-> front_ctrl.internal_ref
        && !front_ctrl.short_inputs) else $error("full step not on internal reference");
    AST_SELF_END: assert property (
        act_ff && self_ff && cnt_ff == 16'(6 * W + 4) |-> !front_ctrl.internal_ref
        && !front_ctrl.short_inputs) else $error("self calibration overran");
    COV_SELF: cover property (cal_wr && bus_req.wdata[1:0] == MODE_SELF);
    COV_SYS_ZS: cover property (cal_wr && bus_req.wdata[1:0] == MODE_SYS_ZS);
    COV_SYS_FS: cover property (cal_wr && bus_req.wdata[1:0] == MODE_SYS_FS);
endmodule : adc_cal_checker

bind adc_calibration_sequencer adc_cal_checker chk (.clk(clk), .arst_n(arst_n),
    .bus_req(bus_req), .rdata(rdata), .meas_word(meas_word), .front_ctrl(front_ctrl),
    .result_ready_n(result_ready_n));

// *** sim/meas_source.sv ***
// Model of the analog path that feeds raw filter words to the sequencer.
`timescale 1ns/1ps
module meas_source
    import adc_cal_pkg::*;
#(
    parameter logic [15:0] SHORT_CODE = 16'h0100, // Word seen with inputs shorted
    parameter logic [15:0] REF_CODE   = 16'hf000  // Word seen on internal reference
)
(
    input front_ctrl_type   front_ctrl, // Front-end control
    input wire logic [15:0] ext_level,  // Word the external input gives
    output logic [15:0]     meas_word   // Raw filter word
);
    // Gain is not modelled: every gain yields the same codes.
    always_comb begin
        if (front_ctrl.short_inputs) begin
            meas_word = SHORT_CODE;
        end else if (front_ctrl.internal_ref) begin
            meas_word = REF_CODE;
        end else begin
            meas_word = ext_level;
        end
    end
endmodule : meas_source

// *** sim/adc_calibration_sequencer_bench.sv ***
// Self-checking bench of the calibration sequencer.
`timescale 1ns/1ps
module adc_calibration_sequencer_bench;
    import adc_cal_pkg::*;
    localparam int W = WORD_CLKS;
    typedef struct packed {
        logic [1:0]  mode;
        logic        bip;
        logic [15:0] ext;
        logic [15:0] zs;
        logic [15:0] fs;
    } row_type;
    logic           clk        = 1'b0;
    logic           arst_n     = 1'b0;
    bus_req_type    bus_req    = '0;
    logic [15:0]    ext_level  = 16'h0000;
    logic [31:0]    rdata;
    logic [15:0]    meas_word;
    front_ctrl_type front_ctrl;
    logic           result_ready_n;
    int             errors       = 0;
    int             total_checks = 0;
    row_type        rows [5] = '{
        '{MODE_SELF,   1'b0, 16'h7880, 16'h0100, 16'hf000},
        '{MODE_SYS_ZS, 1'b0, 16'h0200, 16'h0200, 16'hf000},
        '{MODE_SYS_FS, 1'b0, 16'he000, 16'h0200, 16'he000},
        '{MODE_SYS_ZS, 1'b0, 16'h0300, 16'h0300, 16'he000},
        '{MODE_SELF,   1'b1, 16'h0100, 16'h0100, 16'hf000}};

    adc_calibration_sequencer dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
        .rdata(rdata), .meas_word(meas_word), .front_ctrl(front_ctrl),
        .result_ready_n(result_ready_n));
    meas_source src (.front_ctrl(front_ctrl), .ext_level(ext_level), .meas_word(meas_word));

    always #2 clk = ~clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // Idle lines are inverted so stale values never look like a request.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '{addr: ~a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
        #1;
        v = rdata;
    endtask : bus_read

    function automatic logic [15:0] corr(input longint raw, z, f, input logic bip);
        longint v;
        if (f <= z) return 16'(raw);
        v = bip ? 32768 + (raw - z) * 32768 / (f - z) : (raw - z) * 65535 / (f - z);
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return 16'(v);
    endfunction : corr

    task automatic start_cal(input logic [1:0] mode, input logic bip, input logic [15:0] ext);
        @(posedge clk);
        ext_level <= ext;
        bus_write(SETUP_OFFSET, {25'h0, 1'b1, bip, 3'h5, mode});
        @(posedge clk);
        #1;
        check("ready_start", result_ready_n, 1'b1);
        check("front", front_ctrl, {mode == MODE_SELF, 1'b0, 3'h5, bip, 1'b1});
    endtask : start_cal

    task automatic finish_cal(input int words, input logic [15:0] zs, fs, ext, input logic bip);
        int          cyc;
        logic [31:0] v;
        cyc = 1;
        // The flag is ignored for one modulator cycle after the command.
        while ((result_ready_n !== 1'b0 || cyc <= MOD_CYCLE_CLKS) &&
               cyc < words * W + 8) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        check("ready_delay", cyc >= words * W && cyc <= words * W + 2, 1'b1);
        bus_read(ZS_OFFSET, v);
        check("zs", v, {16'h0, zs});
        bus_read(FS_OFFSET, v);
        check("fs", v, {16'h0, fs});
        bus_read(SETUP_OFFSET, v);
        check("mode", v[1:0], MODE_NORMAL);
        bus_read(STATUS_OFFSET, v);
        check("status_idle", v, 32'h0);
        bus_read(DATA_OFFSET, v);
        check("data", v, {16'h0, corr(ext, zs, fs, bip)});
    endtask : finish_cal

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] v;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (W + 4) @(posedge clk);
        #1;
        check("idle_ready", result_ready_n, 1'b0);
        for (int i = 0; i < 5; i++) begin
            start_cal(rows[i].mode, rows[i].bip, rows[i].ext);
            finish_cal(rows[i].mode == MODE_SELF ? 9 : 4, rows[i].zs, rows[i].fs,
                rows[i].ext, rows[i].bip);
        end
        // A command in mid-calibration restarts the sequence with the new mode.
        start_cal(MODE_SELF, 1'b0, 16'hd000);
        repeat (100) @(posedge clk);
        bus_read(STATUS_OFFSET, v);
        check("status_busy", v, 32'h3);
        start_cal(MODE_SYS_FS, 1'b0, 16'hd000);
        finish_cal(4, 16'h0100, 16'hd000, 16'hd000, 1'b0);
        bus_read(8'h20, v);
        check("unmapped", v, 32'h0);
        // Writing mode zero abandons a calibration in progress.
        start_cal(MODE_SELF, 1'b0, 16'hd000);
        bus_write(SETUP_OFFSET, {25'h0, 1'b1, 1'b0, 3'h5, MODE_NORMAL});
        bus_read(STATUS_OFFSET, v);
        check("status_abort", v, 32'h1);
        bus_read(ZS_OFFSET, v);
        check("zs_abort", v, 32'h0000_0100);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        bus_read(ZS_OFFSET, v);
        check("zs_reset", v, {16'h0, ZS_DEFAULT});
        bus_read(FS_OFFSET, v);
        check("fs_reset", v, {16'h0, FS_DEFAULT});
        test_done();
    end

    initial begin
        #(95000 * CLK_PERIOD_NS);
        errors++;
        test_done();
    end
endmodule : adc_calibration_sequencer_bench
